// file: core/idec_core.sv
// Instruction decoder with cycle timing: one clk per oscillator period.
// Assumes the fetch side presents a stable word in fetch_word while fetch_valid is high.
`timescale 1ns/1ps
`default_nettype none
`include "idec_defs.svh"
module idec_core (
	input  wire logic                 clk,          // Core oscillator
	input  wire logic                 rst_b,        // Async reset, active low
	input  wire logic                 jump_cycle_select, // Option: 1 = two-cycle branches
	input  wire logic [12:0]          fetch_word,   // Instruction from program memory
	input  wire logic                 fetch_valid,  // Word present
	input  wire logic [7:0]           reg_value,    // Value of addressed register
	input  wire logic [7:0]           acc_value,    // Accumulator
	output var  logic                 fetch_take,   // Pulse: word consumed
	output var  idec_pkg::idec_op_t   op,           // Operation latched for execute
	output var  logic [5:0]           reg_sel,      // Register designator
	output var  logic [2:0]           bit_sel,      // Bit designator
	output var  logic [9:0]           literal,      // Literal, 8 or 10 bits
	output var  logic                 exec_strobe,  // Pulse: execute op now
	output var  logic                 skip_taken,   // Level: next instruction squashed
	output var  logic                 flag_we,      // Pulse with exec: Z/C/DC update allowed
	output var  logic [2:0]           flag_mask,    // {Z, C, DC} update enables
	output var  logic                 stack_pop,    // Pulse: top of stack to PC
	output var  logic                 int_enable_set, // Pulse: interrupts enabled
	output var  logic                 watchdog_counter_clear, // Pulse
	output var  logic                 osc_stop,     // Pulse: sleep requested
	output var  logic                 two_cycle     // Level: current op takes two cycles
);
	import idec_pkg::*;

	// ----------------------------------------
	// Decode function
	// ----------------------------------------
	// opcode table
	function automatic idec_op_t decode(input logic [12:0] w);
		idec_op_t o;
		o = IDEC_BAD;
		if (!w[12]) begin
			if (w[11:10] != 2'b00) begin
				case (w[11:10])
					2'b00:   o = IDEC_BAD;
					2'b01:   o = w[9] ? IDEC_BS : IDEC_BC;
					2'b10:   o = w[9] ? IDEC_SKIP_IF_BIT_SET : IDEC_SKIP_IF_BIT_CLEAR;
					default: o = w[9] ? IDEC_SKIP_IF_BIT_SET : IDEC_SKIP_IF_BIT_CLEAR;
				endcase
				if (w[11:9] == 3'b100) o = IDEC_BC;
				else if (w[11:9] == 3'b101) o = IDEC_BS;
				else if (w[11:9] == 3'b110) o = IDEC_SKIP_IF_BIT_CLEAR;
				else if (w[11:9] == 3'b111) o = IDEC_SKIP_IF_BIT_SET;
			end else begin
				case ({w[9:8], w[7:6]})
					4'b0000: begin
						if (w == `IDEC_OP_NOP) o = IDEC_NOP;
						else if (w == `IDEC_OP_DECIMAL_ADJUST) o = IDEC_DECIMAL_ADJUST;
						else if (w == `IDEC_OP_SLEEP) o = IDEC_SLEEP;
						else if (w == `IDEC_OP_WDC) o = IDEC_WDC;
						else if (w[5:4] == 2'b00) o = IDEC_IO_CONTROL_WRITE;
						else if (w == `IDEC_OP_INTERRUPT_ENABLE_INSTRUCTION)
							o = IDEC_INTERRUPT_ENABLE_INSTRUCTION;
						else if (w == `IDEC_OP_INTERRUPT_DISABLE_INSTRUCTION)
							o = IDEC_INTERRUPT_DISABLE_INSTRUCTION;
						else if (w == `IDEC_OP_RET) o = IDEC_RET;
						else if (w == `IDEC_OP_RETURN_FROM_INTERRUPT)
							o = IDEC_RETURN_FROM_INTERRUPT;
						else if (w[5:4] == 2'b01) o = IDEC_IO_CONTROL_READ;
					end
					4'b0001: o = IDEC_MOVRA;
					4'b0010: o = (w == `IDEC_OP_CLRA) ? IDEC_CLRA : IDEC_BAD;
					4'b0011: o = IDEC_CLR;
					4'b0100: o = IDEC_SUBAR;
					4'b0101: o = IDEC_SUBRA;
					4'b0110: o = IDEC_DECA;
					4'b0111: o = IDEC_DEC;
					4'b1000: o = IDEC_ORAR;
					4'b1001: o = IDEC_ORRA;
					4'b1010: o = IDEC_ANDAR;
					4'b1011: o = IDEC_ANDRA;
					4'b1100: o = IDEC_XORAR;
					4'b1101: o = IDEC_XORRA;
					4'b1110: o = IDEC_ADDAR;
					default: o = IDEC_ADDRA;
				endcase
				if (w[9:8] == 2'b00 && w[11:10] == 2'b00 && w[12] == 1'b0) begin
					// Groups 04..07 sit above bit 9; reached via w[11:8] below
				end
			end
			// Groups 0x04..0x07 use bits 10:8 = 1xx with bit 11 clear
			if (w[11] == 1'b0 && w[10] == 1'b1) begin
				case (w[9:6])
					4'b0000: o = IDEC_MOVAR;
					4'b0001: o = IDEC_MOVRR;
					4'b0010: o = IDEC_COMA;
					4'b0011: o = IDEC_COM;
					4'b0100: o = IDEC_INCA;
					4'b0101: o = IDEC_INC;
					4'b0110: o = IDEC_DECREMENT_TO_ACC_SKIP_IF_ZERO;
					4'b0111: o = IDEC_DECREMENT_SKIP_IF_ZERO;
					4'b1000: o = IDEC_RRCA;
					4'b1001: o = IDEC_RRC;
					4'b1010: o = IDEC_RLCA;
					4'b1011: o = IDEC_RLC;
					4'b1100: o = IDEC_SWAPA;
					4'b1101: o = IDEC_SWAP;
					4'b1110: o = IDEC_INCREMENT_TO_ACC_SKIP_IF_ZERO;
					default: o = IDEC_INCREMENT_SKIP_IF_ZERO;
				endcase
			end
		end else begin
			case (w[11:8])
				4'b0000, 4'b0001, 4'b0010, 4'b0011: o = IDEC_CALL;
				4'b0100, 4'b0101, 4'b0110, 4'b0111: o = IDEC_JMP;
				4'b1000: o = IDEC_MOVAK;
				4'b1001: o = IDEC_ORAK;
				4'b1010: o = IDEC_ANDAK;
				4'b1011: o = IDEC_XORAK;
				4'b1100: o = IDEC_RETURN_WITH_LITERAL;
				4'b1101: o = IDEC_SUBAK;
				4'b1110: o = (w[7:4] == 4'h8 && w[3:2] == 2'b00) ? IDEC_PAGE :
					(w[7:4] == 4'h9 && w[3:2] == 2'b00) ? IDEC_BANK : IDEC_BAD;
				default: o = IDEC_ADDAK;
			endcase
		end
		return o;
	endfunction

	// ----------------------------------------
	// Helper classifications
	// ----------------------------------------
	// ops that write their result back to the addressed register
	function automatic logic writes_reg(input idec_op_t o);
		case (o)
			IDEC_MOVRA, IDEC_CLR, IDEC_SUBRA, IDEC_DEC, IDEC_ORRA, IDEC_ANDRA,
			IDEC_XORRA, IDEC_ADDRA, IDEC_MOVRR, IDEC_COM, IDEC_INC,
			IDEC_DECREMENT_SKIP_IF_ZERO, IDEC_RRC, IDEC_RLC, IDEC_SWAP,
			IDEC_INCREMENT_SKIP_IF_ZERO, IDEC_BC, IDEC_BS: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction

	// flags {Z, C, DC} touched per operation
	function automatic logic [2:0] flags_of(input idec_op_t o);
		case (o)
			IDEC_SUBAR, IDEC_SUBRA, IDEC_ADDAR, IDEC_ADDRA, IDEC_SUBAK,
			IDEC_ADDAK: return 3'b111;
			IDEC_DECIMAL_ADJUST, IDEC_RRCA, IDEC_RRC, IDEC_RLCA, IDEC_RLC: return 3'b010;
			IDEC_CLRA, IDEC_CLR, IDEC_DECA, IDEC_DEC, IDEC_ORAR, IDEC_ORRA,
			IDEC_ANDAR, IDEC_ANDRA, IDEC_XORAR, IDEC_XORRA, IDEC_MOVAR,
			IDEC_MOVRR, IDEC_COMA, IDEC_COM, IDEC_INCA, IDEC_INC, IDEC_ORAK,
			IDEC_ANDAK, IDEC_XORAK: return 3'b100;
			default: return 3'b000;
		endcase
	endfunction

	// ----------------------------------------
	// Phase sequencer and decode latch
	// ----------------------------------------
	idec_state_t state, next_state;         // Oscillator phase
	idec_op_t    next_op;                    // Op decoded from fetch
	logic [5:0]  next_reg_sel;               // Register field
	logic [2:0]  next_bit_sel;               // Bit field
	logic [9:0]  next_literal;               // Literal field
	logic        next_take, next_exec, next_skip, next_fwe, next_pop, next_ien;
	logic        next_wdc, next_stop, next_two;
	logic [2:0]  next_fmask;
	logic        skip_now;                   // Current op tests true
	logic [7:0]  bit_val_mask;               // One-hot of addressed bit

	// Combinational next-state: decode on phase 1, execute on phase 2
	always_comb begin
		next_state   = state;
		next_op      = op;
		next_reg_sel = reg_sel;
		next_bit_sel = bit_sel;
		next_literal = literal;
		next_take    = 1'b0;
		next_exec    = 1'b0;
		next_skip    = skip_taken;
		next_fwe     = 1'b0;
		next_fmask   = flag_mask;
		next_pop     = 1'b0;
		next_ien     = 1'b0;
		next_wdc     = 1'b0;
		next_stop    = 1'b0;
		next_two     = two_cycle;
		bit_val_mask = 8'h01 << bit_sel;
		skip_now     = 1'b0;
		if (op == IDEC_DECREMENT_SKIP_IF_ZERO || op == IDEC_DECREMENT_TO_ACC_SKIP_IF_ZERO)
			skip_now = (reg_value == 8'h01);
		// increment wraps to zero means skip
		if (op == IDEC_INCREMENT_SKIP_IF_ZERO || op == IDEC_INCREMENT_TO_ACC_SKIP_IF_ZERO)
			skip_now = (reg_value == 8'hFF);
		if (op == IDEC_SKIP_IF_BIT_SET) skip_now = |(reg_value & bit_val_mask);
		if (op == IDEC_SKIP_IF_BIT_CLEAR) skip_now = ~|(reg_value & bit_val_mask);
		case (state)
			IDEC_EXEC_P1: begin
				if (fetch_valid) begin
					// split the 13-bit word into fields
					next_op      = decode(fetch_word);
					next_reg_sel = fetch_word[5:0];
					next_bit_sel = fetch_word[8:6];
					next_literal = (fetch_word[12:11] == 2'b10) ? fetch_word[9:0] :
						{2'b00, fetch_word[7:0]};
					next_take    = 1'b1;
					next_state   = IDEC_EXEC_P2;
				end
			end
			IDEC_EXEC_P2: begin
				next_state = IDEC_EXEC_P1;
				if (skip_taken) begin
					next_skip = 1'b0;
					next_two  = 1'b0;
				end else begin
					next_exec  = 1'b1;
					next_fwe   = 1'b1;
					next_fmask = flags_of(op);
					next_pop   = (op == IDEC_RET || op == IDEC_RETURN_FROM_INTERRUPT ||
						op == IDEC_RETURN_WITH_LITERAL);
					next_ien   = (op == IDEC_RETURN_FROM_INTERRUPT ||
						op == IDEC_INTERRUPT_ENABLE_INSTRUCTION);
					next_wdc   = (op == IDEC_SLEEP || op == IDEC_WDC);
					next_stop  = (op == IDEC_SLEEP);
					next_skip  = skip_now;
					next_two   = writes_reg(op) && reg_sel == `IDEC_PC_REG;
					// jump and call follow the option bit
					if (op == IDEC_JMP || op == IDEC_CALL) next_two = jump_cycle_select;
					// returns and true skips under two-cycle option
					if (jump_cycle_select && (next_pop || skip_now)) next_two = 1'b1;
					if (next_two) next_state = IDEC_XTRA_P1;
				end
			end
			IDEC_XTRA_P1: next_state = IDEC_XTRA_P2;
			IDEC_XTRA_P2: begin
				next_state = IDEC_EXEC_P1;
				next_two   = 1'b0;
			end
			default: next_state = IDEC_EXEC_P1;
		endcase
	end

	// Registers only; every output straight from a flop
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= IDEC_EXEC_P1;
			op <= IDEC_NOP;
			reg_sel <= 6'h00;
			bit_sel <= 3'h0;
			literal <= 10'h000;
			fetch_take <= 1'b0;
			exec_strobe <= 1'b0;
			skip_taken <= 1'b0;
			flag_we <= 1'b0;
			flag_mask <= 3'h0;
			stack_pop <= 1'b0;
			int_enable_set <= 1'b0;
			watchdog_counter_clear <= 1'b0;
			osc_stop <= 1'b0;
			two_cycle <= 1'b0;
		end else begin
			state <= next_state;
			op <= next_op;
			reg_sel <= next_reg_sel;
			bit_sel <= next_bit_sel;
			literal <= next_literal;
			fetch_take <= next_take;
			exec_strobe <= next_exec;
			skip_taken <= next_skip;
			flag_we <= next_fwe;
			flag_mask <= next_fmask;
			stack_pop <= next_pop;
			int_enable_set <= next_ien;
			watchdog_counter_clear <= next_wdc;
			osc_stop <= next_stop;
			two_cycle <= next_two;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	period_pair_a: assert property (@(posedge clk) disable iff (!rst_b)
		fetch_take |-> ##1 !fetch_take) else $error("fetch closer than one cycle");
	jump_two_a: assert property (@(posedge clk) disable iff (!rst_b)
		(state == IDEC_EXEC_P2 && !skip_taken && op == IDEC_JMP) |=>
		(two_cycle == jump_cycle_select)) else $error("jump timing wrong");
	ret_pop_a: assert property (@(posedge clk) disable iff (!rst_b)
		(state == IDEC_EXEC_P2 && !skip_taken && op == IDEC_RET) |=> stack_pop)
		else $error("return did not pop");
	return_from_interrupt_ien_a: assert property (@(posedge clk) disable iff (!rst_b)
		(state == IDEC_EXEC_P2 && !skip_taken && op == IDEC_RETURN_FROM_INTERRUPT) |=>
		(stack_pop && int_enable_set)) else $error("interrupt return incomplete");
	sleep_stop_a: assert property (@(posedge clk) disable iff (!rst_b)
		osc_stop |-> watchdog_counter_clear) else $error("sleep without clear");
	skip_noexec_a: assert property (@(posedge clk) disable iff (!rst_b)
		(state == IDEC_EXEC_P2 && skip_taken) |=> !exec_strobe)
		else $error("skipped op executed");
	pc_write_a: assert property (@(posedge clk) disable iff (!rst_b)
		(state == IDEC_EXEC_P2 && !skip_taken && op == IDEC_CLR && reg_sel == 6'h02)
		|=> two_cycle ##2 (state == IDEC_EXEC_P1)) else $error("pc write one cycle");
	flag_none_a: assert property (@(posedge clk) disable iff (!rst_b)
		(exec_strobe && (op == IDEC_SWAP || op == IDEC_DECREMENT_SKIP_IF_ZERO)) |->
		flag_mask == 3'b000)
		else $error("flags touched wrongly");
endmodule
`default_nettype wire

// file: core/idec_defs.svh
// Constants for the instruction decoder: field positions, opcode patterns, timing.
// Assumes a 13-bit program word and an 8-bit register file behind the decoder.
// How it works
// - Each instruction is one 13-bit word.
// - One cycle is two oscillator periods.
// - Program counter writes take two cycles.
// - Option bit sets jump/call one or two cycles.
// - Two-cycle option stretches branches and true skips.
// - Any bit set, cleared or tested directly.
// - I/O registers use general register instructions.
// - Register field selects source or destination.
// - Bit field selects bit position.
// - Literals decode as 8 or 10 bits.
// - Return pops stack top into counter.
// - Interrupt return pops and enables interrupts.
// - Sleep and watchdog clear reset counter, flags. The decoder only pulses watchdog_counter_clear; flag_mask stays 000.
// - Decrement-skip writes back, skips on zero.
// - Increment-skip writes back, skips on zero.
`ifndef IDEC_DEFS_SVH
`define IDEC_DEFS_SVH
// ----------------------------------------
// Field layout
// ----------------------------------------
`define IDEC_IW          13
`define IDEC_REG_W       6
`define IDEC_BIT_LSB     6
`define IDEC_LIT8_W      8
`define IDEC_LIT10_W     10
`define IDEC_PC_REG      6'h02
// ----------------------------------------
// Fixed opcodes
// ----------------------------------------
`define IDEC_OP_NOP      13'h0000
`define IDEC_OP_DECIMAL_ADJUST 13'h0001
`define IDEC_OP_SLEEP    13'h0003
`define IDEC_OP_WDC      13'h0004
`define IDEC_OP_INTERRUPT_ENABLE_INSTRUCTION  13'h0010
`define IDEC_OP_INTERRUPT_DISABLE_INSTRUCTION 13'h0011
`define IDEC_OP_RET      13'h0012
`define IDEC_OP_RETURN_FROM_INTERRUPT 13'h0013
`define IDEC_OP_CLRA     13'h0080
// ----------------------------------------
// Timing
// ----------------------------------------
`define IDEC_OSC_PER_CYC 2
`endif

// file: core/idec_pkg.sv
// Types for the instruction decoder: operations and phase states.
// Assumes idec_defs.svh is on the include path.
package idec_pkg;
	// Decoded operation class
	typedef enum logic [5:0] {
		IDEC_NOP, IDEC_DECIMAL_ADJUST, IDEC_SLEEP, IDEC_WDC, IDEC_IO_CONTROL_WRITE,
		IDEC_INTERRUPT_ENABLE_INSTRUCTION, IDEC_INTERRUPT_DISABLE_INSTRUCTION,
		IDEC_RET, IDEC_RETURN_FROM_INTERRUPT, IDEC_IO_CONTROL_READ, IDEC_MOVRA, IDEC_CLRA,
		IDEC_CLR,
		IDEC_SUBAR, IDEC_SUBRA, IDEC_DECA, IDEC_DEC, IDEC_ORAR, IDEC_ORRA,
		IDEC_ANDAR, IDEC_ANDRA, IDEC_XORAR, IDEC_XORRA, IDEC_ADDAR, IDEC_ADDRA,
		IDEC_MOVAR, IDEC_MOVRR, IDEC_COMA, IDEC_COM, IDEC_INCA, IDEC_INC,
		IDEC_DECREMENT_TO_ACC_SKIP_IF_ZERO, IDEC_DECREMENT_SKIP_IF_ZERO,
		IDEC_RRCA, IDEC_RRC, IDEC_RLCA, IDEC_RLC, IDEC_SWAPA, IDEC_SWAP,
		IDEC_INCREMENT_TO_ACC_SKIP_IF_ZERO, IDEC_INCREMENT_SKIP_IF_ZERO, IDEC_BC, IDEC_BS,
		IDEC_SKIP_IF_BIT_CLEAR, IDEC_SKIP_IF_BIT_SET, IDEC_CALL, IDEC_JMP, IDEC_MOVAK,
		IDEC_ORAK, IDEC_ANDAK, IDEC_XORAK, IDEC_RETURN_WITH_LITERAL, IDEC_SUBAK, IDEC_PAGE,
		IDEC_BANK, IDEC_ADDAK,
		IDEC_BAD
	} idec_op_t;
	// Oscillator phase inside an instruction cycle
	typedef enum logic [1:0] {
		IDEC_EXEC_P1, IDEC_EXEC_P2, IDEC_XTRA_P1, IDEC_XTRA_P2
	} idec_state_t;
endpackage

// file: dv/idec_prog_mem.sv
// Program memory model that hands instruction words to the decoder.
// Assumes the bench pushes words only after reset has been released.
`timescale 1ns/1ps
`default_nettype none
module idec_prog_mem (
	input  wire logic        clk,         // Core clock
	input  wire logic        rst_b,       // Reset, active low
	input  wire logic        slow,        // Insert random gaps
	input  wire logic        fetch_take,  // Word consumed
	output var  logic [12:0] fetch_word,  // Instruction word
	output var  logic        fetch_valid, // Word present
	output var  logic [7:0]  reg_value    // Register value paired with word
);
	logic [20:0] mem_q[$]; // Pending {value, word}
	logic [20:0] gone;     // Retired entry
	logic        shown;    // Front entry is on the pins
	logic        hold;     // Keep the taken word's value through its execute phase
	// Queue a word with the register value that goes with it
	task automatic push(input logic [12:0] w, input logic [7:0] v);
		mem_q.push_back({v, w});
	endtask
	initial begin
		shown = 1'b0;
		hold = 1'b0;
		fetch_word = 13'h0000;
		fetch_valid = 1'b0;
		reg_value = 8'h00;
	end
	// ----------------------------------------
	// Offer and retire words on the falling edge
	// ----------------------------------------
	always @(negedge clk) begin
		if (!rst_b) begin
			mem_q.delete();
			shown = 1'b0;
			hold = 1'b0;
		end else if (fetch_take && shown) begin
			gone = mem_q.pop_front();
			shown = 1'b0;
			// The skip tests read the register value in the execute phase
			hold = 1'b1;
		end else begin
			hold = 1'b0;
		end
		// Slow mode stalls about two cycles in three
		if (!hold && !shown && mem_q.size() != 0 && (!slow || $urandom % 3 == 0)) begin
			shown = 1'b1;
		end
		if (shown) begin
			{reg_value, fetch_word} = mem_q[0];
		end else begin
			// Idle bus toggles so a stale word is never mistaken for a fresh one
			fetch_word = ~fetch_word;
		end
		fetch_valid = shown;
	end
endmodule
`default_nettype wire

// file: dv/mcu_instruction_decoder_tb.sv
// Self-checking bench: random and directed words against an integer model.
// Assumes the decoder contract of one take per word and exec one cycle later.
`timescale 1ns/1ps
`default_nettype none
module mcu_instruction_decoder_tb;
	import idec_pkg::*;
	typedef struct {
		logic [12:0] w;    // Word
		idec_op_t    op;   // Expected class
		bit          sq;   // Squashed by a skip
		bit          tk;   // Skip condition true
		logic [2:0]  mask; // {Z, C, DC}
		logic [3:0]  pul;  // {pop, int en, wdt clr, stop}
		logic        two;  // Two instruction cycles
	} idec_exp_t;
	logic clk, rst_b, jump_cycle_select, slow, fetch_valid, fetch_take, exec_strobe;
	logic skip_taken, flag_we, stack_pop, int_enable_set, watchdog_counter_clear;
	logic osc_stop, two_cycle, pend, prev_two, have_prev;
	logic [12:0] fetch_word;
	logic [7:0]  reg_value, acc_value;
	logic [5:0]  reg_sel;
	logic [2:0]  bit_sel, flag_mask;
	logic [9:0]  literal;
	idec_op_t    op;
	idec_exp_t   exp_q[$], cur;
	int failures, samples_checked, gap, seed_dummy;
	logic [12:0] dir[16] = '{13'h0000, 13'h0001, 13'h0003, 13'h0004, 13'h0007, 13'h0010,
		13'h0011, 13'h0012, 13'h0013, 13'h0017, 13'h0080, 13'h00c2, 13'h0042, 13'h1c5a,
		13'h05c2, 13'h1e81};
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	idec_core uut (.clk(clk), .rst_b(rst_b), .jump_cycle_select(jump_cycle_select),
		.fetch_word(fetch_word), .fetch_valid(fetch_valid), .reg_value(reg_value),
		.acc_value(acc_value), .fetch_take(fetch_take), .op(op), .reg_sel(reg_sel),
		.bit_sel(bit_sel), .literal(literal), .exec_strobe(exec_strobe),
		.skip_taken(skip_taken), .flag_we(flag_we), .flag_mask(flag_mask),
		.stack_pop(stack_pop), .int_enable_set(int_enable_set),
		.watchdog_counter_clear(watchdog_counter_clear), .osc_stop(osc_stop),
		.two_cycle(two_cycle));
	idec_prog_mem mem (.clk(clk), .rst_b(rst_b), .slow(slow), .fetch_take(fetch_take),
		.fetch_word(fetch_word), .fetch_valid(fetch_valid), .reg_value(reg_value));
	// ----------------------------------------
	// Reporting
	// ----------------------------------------
	task automatic check(input logic [12:0] seen, input logic [12:0] want, input string what);
		samples_checked++;
		if (seen !== want) begin
			failures++;
			$display("MISMATCH t=%0t %s seen %h want %h", $time, what, seen, want);
		end
	endtask
	task automatic conclude();
		$display("checked %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// ----------------------------------------
	// Reference decode, written from the opcode table
	// ----------------------------------------
	function automatic idec_exp_t predict(input logic [12:0] w, input logic [7:0] v,
			input logic jcs);
		idec_exp_t e;
		logic      wr_r;
		e.w = w;
		e.sq = 1'b0;
		if (w[12]) begin
			case (w[11:8])
				4'h0, 4'h1, 4'h2, 4'h3: e.op = IDEC_CALL;
				4'h4, 4'h5, 4'h6, 4'h7: e.op = IDEC_JMP;
				4'he: e.op = w[4] ? IDEC_BANK : IDEC_PAGE;
				4'hf: e.op = IDEC_ADDAK;
				default: e.op = idec_op_t'(IDEC_MOVAK + w[11:8] - 8);
			endcase
		end else if (w[11]) begin
			e.op = idec_op_t'(IDEC_BC + w[10:9]);
		end else if (w[10:6] == 5'd0) begin
			case (w[5:0])
				6'h00: e.op = IDEC_NOP;
				6'h01: e.op = IDEC_DECIMAL_ADJUST;
				6'h03: e.op = IDEC_SLEEP;
				6'h04: e.op = IDEC_WDC;
				6'h10: e.op = IDEC_INTERRUPT_ENABLE_INSTRUCTION;
				6'h11: e.op = IDEC_INTERRUPT_DISABLE_INSTRUCTION;
				6'h12: e.op = IDEC_RET;
				6'h13: e.op = IDEC_RETURN_FROM_INTERRUPT;
				default: e.op = w[4] ? IDEC_IO_CONTROL_READ : IDEC_IO_CONTROL_WRITE;
			endcase
		end else begin
			e.op = (w[10:6] < 5'd4) ? idec_op_t'(IDEC_NOP + 9 + w[10:6])
				: idec_op_t'(IDEC_SUBAR + w[10:6] - 4);
		end
		// Skip tests: decrement or increment to zero, or a chosen bit
		e.tk = ((e.op == IDEC_DECREMENT_TO_ACC_SKIP_IF_ZERO
				|| e.op == IDEC_DECREMENT_SKIP_IF_ZERO) && v == 8'h01)
			|| ((e.op == IDEC_INCREMENT_TO_ACC_SKIP_IF_ZERO
				|| e.op == IDEC_INCREMENT_SKIP_IF_ZERO) && v == 8'hff)
			|| (e.op == IDEC_SKIP_IF_BIT_CLEAR && !v[w[8:6]])
			|| (e.op == IDEC_SKIP_IF_BIT_SET && v[w[8:6]]);
		e.mask = 3'b000;
		if ((e.op >= IDEC_DECA && e.op <= IDEC_INC) || e.op == IDEC_CLRA || e.op == IDEC_CLR
				|| (e.op >= IDEC_ORAK && e.op <= IDEC_XORAK)) begin
			e.mask = 3'b100;
		end
		case (e.op)
			IDEC_SUBAR, IDEC_SUBRA, IDEC_ADDAR, IDEC_ADDRA, IDEC_SUBAK, IDEC_ADDAK: e.mask = 3'b111;
			IDEC_DECIMAL_ADJUST, IDEC_RRCA, IDEC_RRC, IDEC_RLCA, IDEC_RLC: e.mask = 3'b010;
			default: ;
		endcase
		e.pul = {e.op == IDEC_RET || e.op == IDEC_RETURN_FROM_INTERRUPT
				|| e.op == IDEC_RETURN_WITH_LITERAL,
			e.op == IDEC_RETURN_FROM_INTERRUPT || e.op == IDEC_INTERRUPT_ENABLE_INSTRUCTION,
			e.op == IDEC_SLEEP || e.op == IDEC_WDC,
			e.op == IDEC_SLEEP};
		// Odd groups and bit set/clear write the register operand back
		wr_r = !w[12] && ((!w[11] && w[6]) || (w[11] && !w[10]));
		e.two = (wr_r && w[5:0] == 6'h02) || (jcs && (e.op == IDEC_CALL || e.op == IDEC_JMP
			|| e.pul[3] || e.tk));
		return e;
	endfunction
	// ----------------------------------------
	// Monitor: fields at each take, results one cycle later
	// ----------------------------------------
	always @(negedge clk) begin
		acc_value = 8'($urandom);
		gap++;
		if (!rst_b) begin
			pend = 1'b0;
			have_prev = 1'b0;
		end else begin
			if (pend) begin
				if (cur.sq) begin
					check({flag_we, stack_pop, int_enable_set, watchdog_counter_clear, osc_stop, two_cycle}, 0, "squash");
				end else begin
					check(13'(exec_strobe), 13'h0001, "exec");
					check(13'(flag_we ? flag_mask : 3'b000), 13'(cur.mask), "flags");
					check(13'({stack_pop, int_enable_set, watchdog_counter_clear, osc_stop}), 13'(cur.pul), "pulses");
					check(13'(two_cycle), 13'(cur.two), "two");
				end
				pend = 1'b0;
			end
			if (fetch_take && exp_q.size() == 0) begin
				check(13'h0001, 13'h0000, "extra take");
			end else if (fetch_take) begin
				cur = exp_q.pop_front();
				if (!slow && have_prev) check(13'(gap), prev_two ? 13'd4 : 13'd2, "spacing");
				check(13'(skip_taken), 13'(cur.sq), "skip");
				if (!cur.sq) check(13'(op), 13'(cur.op), "op");
				if (!cur.w[12] && (cur.w[11] || cur.w[10:6] != 0)) check(13'(reg_sel), 13'(cur.w[5:0]), "reg");
				if (!cur.w[12] && cur.w[11]) check(13'(bit_sel), 13'(cur.w[8:6]), "bit");
				if (cur.w[12] && cur.w[11:8] != 4'he) check(13'(literal), cur.w[11] ? 13'(cur.w[7:0]) : 13'(cur.w[9:0]), "lit");
				prev_two = cur.sq ? 1'b0 : cur.two;
				have_prev = 1'b1;
				gap = 0;
				pend = 1'b1;
			end
		end
	end
	// ----------------------------------------
	// One pass: reset, load words, drain or abort
	// ----------------------------------------
	task automatic run(input logic jcs, input logic slow_mode, input int n, input bit abort);
		idec_exp_t e;
		logic [12:0] w;
		logic [7:0]  v;
		bit          sq;
		int          k;
		rst_b = 1'b0;
		jump_cycle_select = jcs;
		slow = slow_mode;
		exp_q.delete();
		repeat (2) @(negedge clk);
		check({fetch_take, exec_strobe, two_cycle, skip_taken, stack_pop, osc_stop, 1'b0, op}, 0, "reset");
		rst_b = 1'b1;
		@(posedge clk);
		sq = 0;
		for (int i = 0; i < n; i++) begin
			w = (i < 16) ? dir[i] : 13'($urandom);
			if (i >= 16 && w[12:6] == 7'h02) w = 13'h0080;
			if (w[12:6] == 7'h00) w[5] = 1'b0;
			if (w[12:8] == 5'h1e) w = {5'h1e, 3'b100, w[4], 2'b00, w[1:0]};
			if (i >= 16 && !w[12] && (w[11] || w[10:6] > 5'd2) && $urandom % 4 == 0) w[5:0] = 6'h02;
			if (sq && jcs) w = 13'h0745;
			k = $urandom % 4;
			v = (k == 0) ? 8'h01 : (k == 1) ? 8'hff : 8'($urandom);
			e = predict(w, v, jcs);
			e.sq = sq;
			// A squashed word never arms a skip of its own
			sq = !sq && e.tk;
			mem.push(w, v);
			exp_q.push_back(e);
		end
		if (abort) begin
			repeat (31) @(negedge clk);
		end else begin
			k = 0;
			while ((exp_q.size() != 0 || pend) && k < 5000) begin
				@(negedge clk);
				k++;
			end
			if (k >= 5000) begin
				failures++;
				conclude();
			end
		end
	endtask
	initial begin
		rst_b = 1'b0;
		jump_cycle_select = 1'b0;
		slow = 1'b0;
		acc_value = 8'h00;
		pend = 1'b0;
		prev_two = 1'b0;
		have_prev = 1'b0;
		gap = 0;
		failures = 0;
		samples_checked = 0;
		seed_dummy = $urandom(32'h8aa096fd);
		run(1'b0, 1'b0, 150, 1'b0);
		run(1'b1, 1'b0, 150, 1'b0);
		run(1'b1, 1'b1, 40, 1'b1);
		run(1'b1, 1'b1, 120, 1'b0);
		run(1'b0, 1'b1, 120, 1'b0);
		conclude();
	end
endmodule
`default_nettype wire
